//--- rtl/wem_pkg.sv
// Package: constants and types for the waveform envelope anomaly monitor
package wem_pkg;
  localparam int WEM_SAMPLE_W = 8;
  localparam int WEM_COUNT_W = 16;
  localparam logic [15:0] WEM_CNT_RST = 16'h0000;
  localparam logic [3:0] WEM_ACT_RST = 4'h0;
  localparam int WEM_ACT_SAVE = 0;
  localparam int WEM_ACT_COPY = 1;
  localparam int WEM_ACT_CHIME = 2;
  localparam int WEM_ACT_REMOTE = 3;
  typedef enum logic [1:0] {
    WEM_IDLE = 2'b00,
    WEM_RUN = 2'b01,
    WEM_ACT = 2'b11,
    WEM_STOP = 2'b10
  } wem_state_t;
endpackage : wem_pkg

//--- rtl/wem_cmp.sv
// Point comparator: test sample against one envelope min/max pair
`timescale 1ns/10ps
module wem_cmp #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] env_min,
  input wire logic [W-1:0] env_max,
  output logic outside
);
  always_comb begin
    outside = (sample < env_min) || (sample > env_max); // [RULE13]
  end
endmodule : wem_cmp

//--- rtl/wem_monitor.sv
// Top: waveform envelope anomaly monitor with delta event actions
//
// How it works
// [RULE1] Check each test point against envelope bounds
// [RULE2] Reference must be an envelope record
// [RULE3] Reference holds at least test record points
// [RULE4] Surplus reference points never reach comparison
// [RULE5] Event fires enabled save, copy, chime, remote
// [RULE6] Flag every out-of-envelope point individually
// [RULE7] Stop acquisition when delta event detected
// [RULE8] Auto restart resumes, else remain stopped
// [RULE9] Reference may be stored or live
// [RULE10] Tolerance thresholds suppress small deviations
// [RULE11] Event needs total and consecutive thresholds
// [RULE12] Test record is displayed, reference envelope
// [RULE13] Out when below minimum or above maximum
// [RULE14] Counters clear per record; run clears in-bounds
`timescale 1ns/10ps
module wem_monitor #(
  parameter int SAMPLE_W = wem_pkg::WEM_SAMPLE_W,
  parameter int COUNT_W = wem_pkg::WEM_COUNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic auto_restart,
  input wire logic [3:0] action_en,
  input wire logic [COUNT_W-1:0] total_thresh,
  input wire logic [COUNT_W-1:0] consec_thresh,
  input wire logic rec_start,
  input wire logic pt_valid,
  input wire logic pt_last,
  input wire logic [SAMPLE_W-1:0] pt_sample,
  input wire logic [SAMPLE_W-1:0] ref_min,
  input wire logic [SAMPLE_W-1:0] ref_max,
  input wire logic action_done,
  output logic acq_run,
  output logic pt_out_valid,
  output logic pt_outside,
  output logic delta_event,
  output logic save_req,
  output logic copy_req,
  output logic chime_req,
  output logic remote_req,
  output logic stopped,
  output logic [COUNT_W-1:0] total_count,
  output logic [COUNT_W-1:0] consec_count
);
  import wem_pkg::*;

  // Counter reset constant is 16 bits, so wider counters are refused
  if (SAMPLE_W < 1) begin : g_bad_sample_w
    $error("wem_monitor: SAMPLE_W must be at least 1");
  end
  if (COUNT_W < 2 || COUNT_W > 16) begin : g_bad_count_w
    $error("wem_monitor: COUNT_W must be 2 to 16");
  end

  wem_state_t state_q, state_d;
  logic [COUNT_W-1:0] tot_q, tot_d, run_q, run_d, best_q, best_d;
  logic hit_q, hit_d;
  logic mark_q, mark_d, mval_q, mval_d;
  logic [3:0] req_q, req_d;
  logic evt_q, evt_d;
  logic outside;

  function automatic logic [COUNT_W-1:0] sat_inc(
    input logic [COUNT_W-1:0] v
  );
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  // Zero thresholds still need one out point, so a clean record is quiet
  function automatic logic thresh_met(
    input logic [COUNT_W-1:0] tot,
    input logic [COUNT_W-1:0] best,
    input logic [COUNT_W-1:0] tot_min,
    input logic [COUNT_W-1:0] run_min
  );
    thresh_met = (tot >= tot_min) && (best >= run_min) && (tot != '0);
  endfunction : thresh_met

  // A record may open on the very point that is being counted
  logic [COUNT_W-1:0] tot_base, run_base, best_base;
  assign tot_base = rec_start ? WEM_CNT_RST[COUNT_W-1:0] : tot_q;
  assign run_base = rec_start ? WEM_CNT_RST[COUNT_W-1:0] : run_q;
  assign best_base = rec_start ? WEM_CNT_RST[COUNT_W-1:0] : best_q;

  // Reference pairs arrive aligned to test points only, so extras never
  // enter; stored or live limits look the same here.
  wem_cmp #(.W(SAMPLE_W)) u_cmp ( // [RULE4] [RULE9]
    .sample(pt_sample),
    .env_min(ref_min),
    .env_max(ref_max),
    .outside(outside)
  ); // [RULE1]

  logic take;
  assign take = (state_q == WEM_RUN) && pt_valid;

  always_comb begin
    state_d = state_q;
    tot_d = tot_q;
    run_d = run_q;
    best_d = best_q;
    hit_d = hit_q;
    mark_d = 1'b0;
    mval_d = 1'b0;
    req_d = WEM_ACT_RST;
    evt_d = 1'b0;
    case (state_q)
      WEM_IDLE: begin
        if (enable) begin
          state_d = WEM_RUN;
        end
      end
      WEM_RUN: begin
        if (!enable) begin
          state_d = WEM_IDLE;
        end else begin
          // A new record forgets all earlier counts
          if (rec_start) begin
            tot_d = WEM_CNT_RST[COUNT_W-1:0]; // [RULE14]
            run_d = WEM_CNT_RST[COUNT_W-1:0]; // [RULE14]
            best_d = WEM_CNT_RST[COUNT_W-1:0];
            hit_d = 1'b0;
          end
          if (take) begin
            mval_d = 1'b1;
            mark_d = outside; // [RULE6]
            if (outside) begin
              tot_d = sat_inc(tot_base);
              run_d = sat_inc(run_base);
              if (run_d > best_base) begin
                best_d = run_d;
              end
            end else begin
              run_d = '0; // [RULE14]
            end
            if (thresh_met(tot_d, best_d, total_thresh, consec_thresh)) begin
              hit_d = 1'b1; // [RULE10] [RULE11]
            end
            // Event decided at record end so the full record is saved
            if (pt_last && (hit_d)) begin
              state_d = WEM_ACT; // [RULE7]
              evt_d = 1'b1;
              req_d = action_en; // [RULE5]
            end
          end
        end
      end
      WEM_ACT: begin
        // No action enabled: nothing to wait for
        if (action_done || action_en == WEM_ACT_RST) begin
          state_d = auto_restart ? WEM_RUN : WEM_STOP; // [RULE8]
          hit_d = 1'b0;
        end
      end
      WEM_STOP: begin
        if (!enable) begin
          state_d = WEM_IDLE; // [RULE8]
        end
      end
      default: begin
        state_d = WEM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= WEM_IDLE;
      tot_q <= '0;
      run_q <= '0;
      best_q <= '0;
      hit_q <= 1'b0;
      mark_q <= 1'b0;
      mval_q <= 1'b0;
      req_q <= WEM_ACT_RST;
      evt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tot_q <= tot_d;
      run_q <= run_d;
      best_q <= best_d;
      hit_q <= hit_d;
      mark_q <= mark_d;
      mval_q <= mval_d;
      req_q <= req_d;
      evt_q <= evt_d;
    end
  end

  // Status from flops, so the acquisition path sees clean levels
  logic acq_q, acq_d, stp_q, stp_d;

  always_comb begin
    acq_d = (state_d == WEM_RUN); // [RULE7]
    stp_d = (state_d == WEM_STOP); // [RULE8]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acq_q <= 1'b0;
      stp_q <= 1'b0;
    end else begin
      acq_q <= acq_d;
      stp_q <= stp_d;
    end
  end

  assign acq_run = acq_q; // [RULE7]
  assign stopped = stp_q;
  assign pt_out_valid = mval_q;
  assign pt_outside = mark_q;
  assign delta_event = evt_q;
  // Each enabled request bit pulses together with the event
  assign save_req = req_q[WEM_ACT_SAVE];
  assign copy_req = req_q[WEM_ACT_COPY];
  assign chime_req = req_q[WEM_ACT_CHIME];
  assign remote_req = req_q[WEM_ACT_REMOTE];
  assign total_count = tot_q;
  assign consec_count = best_q;
endmodule : wem_monitor

//--- bench/wem_act_model.sv
// Action logic model: ends each action phase after a delay
`timescale 1ns/10ps
module wem_act_model #(
  parameter int DLY = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic delta_event,
  output logic action_done
);
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 0;
    else cnt <= delta_event ? DLY : (cnt > 0 ? cnt - 1 : 0);
  end
  assign action_done = (cnt == 1);
endmodule : wem_act_model

//--- bench/wem_chk.sv
// Checker: port assertions for the envelope monitor
`timescale 1ns/10ps
module wem_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic acq_run,
  input wire logic pt_valid,
  input wire logic pt_out_valid,
  input wire logic pt_outside,
  input wire logic delta_event,
  input wire logic save_req,
  input wire logic copy_req,
  input wire logic chime_req,
  input wire logic remote_req,
  input wire logic [3:0] action_en,
  input wire logic stopped
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ack; acq_run && pt_valid |=> pt_out_valid; endproperty
  a_ack: assert property (p_ack) else $error("point unanswered");
  property p_flg; pt_outside |-> pt_out_valid; endproperty
  a_flg: assert property (p_flg) else $error("stray flag");
  property p_hlt; delta_event |-> !acq_run; endproperty
  a_hlt: assert property (p_hlt) else $error("still running");
  property p_one; delta_event |=> !delta_event; endproperty
  a_one: assert property (p_one) else $error("long event");
  property p_end; delta_event |-> pt_out_valid; endproperty
  a_end: assert property (p_end) else $error("event off record");
  property p_sav;
    delta_event |-> {remote_req, chime_req, copy_req, save_req} == action_en;
  endproperty
  a_sav: assert property (p_sav) else $error("action mismatch");
  property p_req;
    (save_req || copy_req || chime_req || remote_req) |-> delta_event;
  endproperty
  a_req: assert property (p_req) else $error("request no event");
  property p_stp; stopped && enable |=> stopped && !acq_run; endproperty
  a_stp: assert property (p_stp) else $error("left stop");
  cover property (delta_event && action_en == 4'hF);
  cover property (stopped);
  cover property (pt_outside);
endmodule : wem_chk

bind wem_monitor wem_chk i_chk (.clk, .rst, .enable, .acq_run, .pt_valid,
  .pt_out_valid, .pt_outside, .delta_event, .save_req, .copy_req,
  .chime_req, .remote_req, .action_en, .stopped);

//--- bench/tb_top.sv
// Testbench: record scenarios for the envelope monitor
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'h0, rst = 1'h1, enable = 1'h1, auto_restart = 1'h1;
  logic rec_start = 1'h0, pt_valid = 1'h0, pt_last = 1'h0, action_done;
  logic acq_run, pt_out_valid, pt_outside, delta_event, stopped;
  logic save_req, copy_req, chime_req, remote_req;
  logic [3:0] action_en = 4'hF, acts;
  logic [7:0] pt_sample = 8'h00, seen, ref_min = 8'h20, ref_max = 8'h80;
  logic [15:0] total_thresh = 16'h0003, consec_thresh = 16'h0002;
  logic [15:0] total_count, consec_count;
  int n_mismatch = 0, comparisons = 0, n_evt = 0, n_pv = 0;
  always #5 clk = ~clk;
  wem_monitor i_dut (.clk, .rst, .enable, .auto_restart, .action_en,
    .total_thresh, .consec_thresh, .rec_start, .pt_valid, .pt_last,
    .pt_sample, .ref_min, .ref_max, .action_done, .acq_run, .pt_out_valid,
    .pt_outside, .delta_event, .save_req, .copy_req, .chime_req,
    .remote_req, .stopped, .total_count, .consec_count);
  wem_act_model i_act (.clk, .rst, .delta_event, .action_done);
  // Sample on the falling edge, away from launch races
  always @(negedge clk) begin
    if (pt_out_valid === 1'h1) seen = {pt_outside, seen[7:1]};
    if (delta_event === 1'h1) acts = {remote_req, chime_req, copy_req, save_req};
    n_evt += (delta_event === 1'h1);
    n_pv += (pt_out_valid === 1'h1);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) n_mismatch++;
    if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
  endtask : chk
  // Inside points sit exactly on the envelope edges; the limits are live
  task automatic rec(input logic [7:0] m);
    int pv0;
    logic [7:0] lo;
    pv0 = n_pv;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      lo = 8'h20 + 8'(i);
      rec_start <= (i == 0);
      pt_valid <= 1'h1;
      pt_last <= (i == 7);
      ref_min <= lo;
      ref_max <= lo + 8'h60;
      pt_sample <= m[i] ? (i[0] ? lo + 8'h61 : lo - 8'h01) :
        (i[0] ? lo + 8'h60 : lo);
    end
    @(posedge clk);
    pt_valid <= 1'h0;
    pt_last <= 1'h0;
    repeat (4) @(negedge clk);
    chk({8'h00, seen}, {8'h00, m});
    chk(16'(n_pv - pv0), 16'h0008);
  endtask : rec
  task automatic sc_tol;
    rec(8'h54);
    chk({total_count[7:0], consec_count[7:0]}, 16'h0301);
    rec(8'h1A);
    chk({total_count[7:0], consec_count[7:0]}, 16'h0302);
    repeat (9) @(negedge clk);
    chk({acts, 3'h0, acq_run, n_evt[7:0]}, 16'hF101);
  endtask : sc_tol
  task automatic sc_stop;
    @(posedge clk);
    auto_restart <= 1'h0;
    action_en <= 4'h5;
    total_thresh <= 16'h0001;
    consec_thresh <= 16'h0001;
    rec(8'h80);
    repeat (9) @(negedge clk);
    chk({acts, 2'h0, stopped, acq_run, n_evt[7:0]}, 16'h5202);
  endtask : sc_stop
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    sc_tol();
    sc_stop();
    tally_and_finish();
  end
  initial begin
    #20000 n_mismatch++;
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
endmodule : tb_top
